/* rtl/hpp_device.sv */
// device end of the parallel host port: pin decode and register steering
module hpp_device
    import hpp_pkg::*;
#(
    parameter int DEPTH = hpp_pkg::HPP_FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    hpp_if.device pins,
    input wire logic float_all_n,
    input wire logic wide_host_mode_strap,
    input wire logic port_enable_strap,
    input wire logic [15:0] bank_switch_control_reg,
    input wire logic gpio_mode,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    output logic [7:0] gpio_in,
    output logic [15:0] host_address_reg,
    output logic [15:0] host_ctrl_reg,
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    output logic port_enabled,
    output logic holder_on
);
    import hpp_pkg::*;
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] ds_s;
        logic [3:0] sel_s;
        logic [1:0] bil_s;
        logic [1:0] rw_s;
        logic [1:0] as_s;
        logic [15:0] dq1;
        logic [7:0] dq2;
        logic act_r;
        logic as_r;
        logic en_r;
        logic en_cap_r;
        logic [7:0] lo_r;
        logic [7:0] dout_r;
        logic drive_r;
        logic [15:0] addr_r;
        logic [15:0] ctrl_r;
        logic [7:0] gin_r;
    } hpp_dst_t;
    hpp_dst_t s_r, s_nxt;
    logic act, strobe, ff_in_ready, ff_in_valid;
    logic [1:0] sel;
    logic first_byte;
    logic [15:0] ff_in_data;
    // second sync stage only is used anywhere below
    assign act = !s_r.cs_s[1] && !(s_r.ds_s[1]);
    assign sel = wide_host_mode_strap ? HPP_SEL_WIDE : s_r.sel_s[3:2];
    assign first_byte = wide_host_mode_strap ? 1'b0 : !s_r.bil_s[1];
    assign strobe = act && !s_r.act_r;
    always_comb begin
        s_nxt = s_r;
        ff_in_valid = 1'b0;
        ff_in_data = {s_r.lo_r, s_r.dq2};
        // two-flop sync on every host control input
        s_nxt.cs_s = {s_r.cs_s[0], pins.port_select_n};
        s_nxt.ds_s = {s_r.ds_s[0],
            pins.data_strobe_a_n & pins.data_strobe_b_n};
        s_nxt.sel_s = {s_r.sel_s[1:0],
            pins.host_reg_select_hi, pins.host_reg_select_lo};
        s_nxt.bil_s = {s_r.bil_s[0], pins.byte_ident_in};
        s_nxt.rw_s = {s_r.rw_s[0], pins.transfer_direction_in};
        s_nxt.as_s = {s_r.as_s[0], pins.address_strobe_n};
        s_nxt.dq1 = {s_r.dq1[7:0], pins.d_i};
        s_nxt.dq2 = s_r.dq1[15:8];
        s_nxt.act_r = act;
        s_nxt.as_r = s_r.as_s[1];
        s_nxt.gin_r = pins.d_i;
        if (!s_r.en_cap_r) begin
            s_nxt.en_r = port_enable_strap;
            s_nxt.en_cap_r = 1'b1;
        end
        if (s_r.as_r && !s_r.as_s[1]) begin
            s_nxt.addr_r = {s_r.addr_r[7:0], s_r.dq2};
        end
        if (!act) s_nxt.drive_r = 1'b0;
        if (strobe && s_r.en_r) begin
            if (s_r.rw_s[1]) begin
                s_nxt.drive_r = 1'b1;
                case (sel)
                    HPP_SEL_CTRL: s_nxt.dout_r = first_byte ?
                        s_r.ctrl_r[15:8] : s_r.ctrl_r[7:0];
                    HPP_SEL_ADDR: s_nxt.dout_r = first_byte ?
                        s_r.addr_r[15:8] : s_r.addr_r[7:0];
                    default: s_nxt.dout_r = first_byte ?
                        rd_data[15:8] : rd_data[7:0];
                endcase
            end else begin
                case (sel)
                    HPP_SEL_CTRL: if (first_byte) begin
                        s_nxt.ctrl_r[15:8] = s_r.dq2;
                    end else begin
                        s_nxt.ctrl_r[7:0] = s_r.dq2;
                    end
                    HPP_SEL_ADDR: if (first_byte) begin
                        s_nxt.addr_r[15:8] = s_r.dq2;
                    end else begin
                        s_nxt.addr_r[7:0] = s_r.dq2;
                    end
                    default: if (first_byte) begin
                        s_nxt.lo_r = s_r.dq2;
                    end else begin
                        ff_in_valid = 1'b1;
                        if (sel == HPP_SEL_DATA_INC && ff_in_ready) begin
                            s_nxt.addr_r = s_r.addr_r + 16'h0001;
                        end
                    end
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.cs_s <= 2'h3;
            s_r.ds_s <= 2'h3;
            s_r.as_s <= 2'h3;
            s_r.as_r <= 1'b1;
            s_r.ctrl_r <= HPP_BANK_SWITCH_CONTROL_REG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end
    // fifo absorbs bursts; when full the ready pin drops to stall the host
    hpp_fifo #(.W(HPP_WORD_W), .D(DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(ff_in_valid),
        .in_ready(ff_in_ready),
        .in_data(ff_in_data),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr_data)
    );
    // holder_on only mirrors the holder bit of bank_switch_control_reg; the hpp_if bus keeper holds the old level whatever its value
    assign holder_on = bank_switch_control_reg[HPP_HOLDER_BIT];
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pins.dev_d_oe[i] = float_all_n && (gpio_mode ? gpio_oe[i] :
                (s_r.drive_r && act));
        end
    end
    assign pins.dev_d_o = gpio_mode ? gpio_out : s_r.dout_r;
    assign pins.port_ready_out = !presetn || (ff_in_ready && !strobe);
    assign gpio_in = s_r.gin_r;
    assign host_address_reg = s_r.addr_r;
    assign host_ctrl_reg = s_r.ctrl_r;
    assign port_enabled = s_r.en_r;
endmodule // hpp_device

/* shared/hpp_pkg.sv */
// shared constants and types for the parallel host port pin block
package hpp_pkg;
    localparam int HPP_DATA_W = 8;
    localparam int HPP_WORD_W = 16;
    localparam int HPP_FIFO_DEPTH = 16;
    // register select codes on {host_reg_select_hi, host_reg_select_lo}
    localparam logic [1:0] HPP_SEL_CTRL = 2'h0;
    localparam logic [1:0] HPP_SEL_DATA_INC = 2'h1;
    localparam logic [1:0] HPP_SEL_ADDR = 2'h2;
    localparam logic [1:0] HPP_SEL_DATA = 2'h3;
    // wide mode always targets the data register
    localparam logic [1:0] HPP_SEL_WIDE = HPP_SEL_DATA;
    // host-side APB register offsets
    localparam logic [7:0] HPP_OFF_CMD = 8'h00;
    localparam logic [7:0] HPP_OFF_WDATA = 8'h04;
    localparam logic [7:0] HPP_OFF_RDATA = 8'h08;
    localparam logic [7:0] HPP_OFF_STAT = 8'h0c;
    // command register fields
    localparam int HPP_CMD_SEL_LSB = 0;
    localparam int HPP_CMD_DIR_BIT = 2;
    localparam int HPP_CMD_GO_BIT = 3;
    localparam int HPP_CMD_ALE_BIT = 4;
    // strobe phase lengths in pclk cycles, host side
    localparam int HPP_SETUP_CYC = 2;
    localparam int HPP_STROBE_CYC = 6;
    localparam logic [15:0] HPP_BANK_SWITCH_CONTROL_REG_RST = 16'h0000;
    localparam int HPP_HOLDER_BIT = 0;
    typedef enum logic [3:0] {
        HPP_H_IDLE = 4'b0001,
        HPP_H_SETUP = 4'b0010,
        HPP_H_STROBE = 4'b0100,
        HPP_H_HOLD = 4'b1000
    } hpp_hstate_t;
endpackage : hpp_pkg

/* shared/hpp_if.sv */
// pin-level link between the host processor and the host port
interface hpp_if;
    logic [7:0] dev_d_o;
    logic [7:0] dev_d_oe;
    logic [7:0] host_d_o;
    logic host_d_oe;
    logic [7:0] d_i;
    logic host_reg_select_lo;
    logic host_reg_select_hi;
    logic byte_ident_in;
    logic port_select_n;
    logic data_strobe_a_n;
    logic data_strobe_b_n;
    logic address_strobe_n;
    logic transfer_direction_in;
    logic port_ready_out;
    // wired bus level resolved from the enables; bus keeper holds old level
    logic [7:0] keep_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (dev_d_oe[i]) begin
                d_i[i] = dev_d_o[i];
            end else if (host_d_oe) begin
                d_i[i] = host_d_o[i];
            end else begin
                d_i[i] = keep_r[i];
            end
        end
    end
    always @(d_i) keep_r = d_i;
    modport device (
        output dev_d_o, dev_d_oe, port_ready_out,
        input d_i, host_reg_select_lo, host_reg_select_hi, byte_ident_in,
        port_select_n, data_strobe_a_n, data_strobe_b_n, address_strobe_n,
        transfer_direction_in
    );
    modport host (
        output host_d_o, host_d_oe, host_reg_select_lo, host_reg_select_hi,
        byte_ident_in, port_select_n, data_strobe_a_n, data_strobe_b_n,
        address_strobe_n, transfer_direction_in,
        input d_i, port_ready_out
    );
endinterface : hpp_if

/* rtl/hpp_fifo.sv */
// parameterised valid/ready fifo
module hpp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } hpp_fst_t;
    hpp_fst_t s_r, s_nxt;
    logic [W-1:0] mem [D];
    logic full, empty;
    assign empty = s_r.wp == s_r.rp;
    assign full = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && !empty;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[s_r.rp[AW-1:0]];
    always_comb begin
        s_nxt = s_r;
        if (in_valid && !full) s_nxt.wp = s_r.wp + 1'b1;
        if (out_ready && !empty) s_nxt.rp = s_r.rp + 1'b1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    always_ff @(posedge pclk) begin
        if (in_valid && !full) mem[s_r.wp[AW-1:0]] <= in_data;
    end
endmodule // hpp_fifo

/* rtl/hpp_host.sv */
// host end: APB-programmed strobe sequencer for the host port pins
module hpp_host
    import hpp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    hpp_if.host pins
);
    import hpp_pkg::*;
    typedef struct packed {
        hpp_hstate_t st;
        logic [4:0] cmd;
        logic [8:0] wd;
        logic [7:0] rd;
        logic [3:0] cnt;
        logic busy;
        logic [31:0] prd;
    } hpp_hst_t;
    hpp_hst_t s_r, s_nxt;
    logic wr_acc, rd_acc, hit;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign hit = paddr == HPP_OFF_CMD || paddr == HPP_OFF_WDATA ||
        paddr == HPP_OFF_RDATA || paddr == HPP_OFF_STAT;
    always_comb begin
        s_nxt = s_r;
        if (wr_acc && paddr == HPP_OFF_WDATA) begin
            s_nxt.wd = pwdata[8:0];
        end else if (wr_acc && paddr == HPP_OFF_CMD && !s_r.busy) begin
            s_nxt.cmd = pwdata[4:0];
            s_nxt.busy = pwdata[HPP_CMD_GO_BIT];
        end
        if (paddr == HPP_OFF_RDATA) begin
            s_nxt.prd = {24'h0, s_r.rd};
        end else if (paddr == HPP_OFF_STAT) begin
            s_nxt.prd = {31'h0, s_r.busy};
        end else if (paddr == HPP_OFF_CMD) begin
            s_nxt.prd = {27'h0, s_r.cmd};
        end else if (paddr == HPP_OFF_WDATA) begin
            s_nxt.prd = {23'h0, s_r.wd};
        end else begin
            s_nxt.prd = 32'h0;
        end
        case (s_r.st)
            HPP_H_IDLE: if (s_r.busy && pins.port_ready_out) begin
                s_nxt.st = HPP_H_SETUP;
                s_nxt.cnt = 4'(HPP_SETUP_CYC);
            end
            HPP_H_SETUP: if (s_r.cnt == 4'h1) begin
                s_nxt.st = HPP_H_STROBE;
                s_nxt.cnt = 4'(HPP_STROBE_CYC);
            end else begin
                s_nxt.cnt = s_r.cnt - 4'h1;
            end
            HPP_H_STROBE: if (s_r.cnt == 4'h1) begin
                s_nxt.rd = pins.d_i;
                s_nxt.st = HPP_H_HOLD;
            end else begin
                s_nxt.cnt = s_r.cnt - 4'h1;
            end
            HPP_H_HOLD: begin
                s_nxt.st = HPP_H_IDLE;
                s_nxt.busy = 1'b0;
            end
            default: s_nxt.st = HPP_H_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.st <= HPP_H_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign prdata = s_r.prd;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    // select spans setup, strobe and hold so it covers the access
    assign pins.port_select_n = s_r.st == HPP_H_IDLE;
    assign pins.data_strobe_a_n = s_r.st != HPP_H_STROBE;
    assign pins.data_strobe_b_n = 1'b1;
    assign pins.address_strobe_n = !(s_r.st == HPP_H_SETUP &&
        s_r.cmd[HPP_CMD_ALE_BIT]);
    assign pins.transfer_direction_in = s_r.cmd[HPP_CMD_DIR_BIT];
    assign pins.host_reg_select_lo = s_r.cmd[HPP_CMD_SEL_LSB];
    assign pins.host_reg_select_hi = s_r.cmd[HPP_CMD_SEL_LSB+1];
    assign pins.byte_ident_in = s_r.wd[8];
    assign pins.host_d_o = s_r.wd[7:0];
    assign pins.host_d_oe = !s_r.cmd[HPP_CMD_DIR_BIT] &&
        s_r.st != HPP_H_IDLE;
endmodule // hpp_host

/* bench/hpp_properties.sv */
// concurrent checks on the pin link between host and device ends
module hpp_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic float_all_n,
    input wire logic gpio_mode,
    input wire logic [7:0] dev_d_o,
    input wire logic [7:0] dev_d_oe,
    input wire logic port_select_n,
    input wire logic data_strobe_a_n,
    input wire logic data_strobe_b_n,
    input wire logic transfer_direction_in,
    input wire logic port_ready_out
);
    logic stb;
    assign stb = !data_strobe_a_n || !data_strobe_b_n;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_start;
        !port_select_n && $rose(stb);
    endsequence
    sequence s_read;
        s_start ##0 (transfer_direction_in && float_all_n && !gpio_mode);
    endsequence
    AST_READY_RESET: assert property ($rose(presetn) |-> $past(port_ready_out))
        else $error("ready not high in reset");
    AST_FLOAT_ALL: assert property ((!float_all_n)[*2] |-> dev_d_oe == 8'h00)
        else $error("data driven while floated");
    AST_IDLE_FLOAT: assert property
        ((port_select_n && !gpio_mode)[*4] |-> dev_d_oe == 8'h00)
        else $error("data driven while idle");
    AST_READ_DRIVE: assert property (s_read |-> ##[1:5] dev_d_oe == 8'hff)
        else $error("read data not driven");
    AST_WRITE_QUIET: assert property
        ((stb && !port_select_n && !transfer_direction_in)[*3]
        |-> dev_d_oe == 8'h00)
        else $error("data driven during write");
    AST_READY_DROP: assert property (s_start |-> ##[0:3] !port_ready_out)
        else $error("ready not dropped on strobe");
    AST_SEL_HELD: assert property (stb |-> !port_select_n)
        else $error("strobe without select");
    AST_STROBE_LEN: assert property (s_start |-> stb[*6] ##1 !stb)
        else $error("strobe length wrong");
    AST_SETUP: assert property ($fell(port_select_n) |-> !stb[*2] ##1 stb)
        else $error("select setup wrong");
    AST_READ_HOLD: assert property
        ((stb && dev_d_oe == 8'hff && transfer_direction_in) ##1 stb
        |-> $stable(dev_d_o))
        else $error("read data moved under strobe");
endmodule // hpp_properties

/* bench/host_port_pin_interface_tb.sv */
// self-checking bench for both ends of the host port pin link
`define CHK(nm, ex, got) begin check_count++; \
    if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module host_port_pin_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hpp_pkg::*;
    typedef struct packed {
        logic [1:0] sel;
        logic [15:0] din;
        logic [15:0] rd;
    } hpp_row_t;
    logic pclk, pready, pslverr, wr_valid, port_enabled, holder_on;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic float_all_n = 1'b1, wide_host_mode_strap = 1'b0, wr_ready = 1'b0;
    logic port_enable_strap = 1'b1, gpio_mode = 1'b0;
    logic [7:0] paddr = 8'h00, gpio_out = 8'h00, gpio_oe = 8'h00, gpio_in;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [15:0] bank_switch_control_reg = HPP_BANK_SWITCH_CONTROL_REG_RST, rd_data = 16'h0;
    logic [15:0] host_address_reg, host_ctrl_reg, wr_data;
    logic e;
    int err_count = 0, check_count = 0;
    hpp_row_t rows [4] = '{'{HPP_SEL_DATA, 16'h12a5, 16'h5a3c},
        '{HPP_SEL_DATA_INC, 16'h00ff, 16'hff00},
        '{HPP_SEL_ADDR, 16'hbeef, 16'h0000},
        '{HPP_SEL_CTRL, 16'hc3a5, 16'h0000}};
    hpp_if u_hpp_if();
    hpp_host u_hpp_host(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pins(u_hpp_if));
    hpp_device #(.DEPTH(HPP_FIFO_DEPTH)) u_hpp_device(.pclk, .presetn,
        .pins(u_hpp_if), .float_all_n, .wide_host_mode_strap,
        .port_enable_strap, .bank_switch_control_reg, .gpio_mode, .gpio_out,
        .gpio_oe, .gpio_in, .host_address_reg, .host_ctrl_reg, .wr_valid,
        .wr_ready, .wr_data, .rd_data, .port_enabled, .holder_on);
    hpp_properties u_hpp_properties(.pclk, .presetn, .float_all_n,
        .gpio_mode, .dev_d_o(u_hpp_if.dev_d_o),
        .dev_d_oe(u_hpp_if.dev_d_oe), .port_select_n(u_hpp_if.port_select_n),
        .data_strobe_a_n(u_hpp_if.data_strobe_a_n),
        .data_strobe_b_n(u_hpp_if.data_strobe_b_n),
        .transfer_direction_in(u_hpp_if.transfer_direction_in),
        .port_ready_out(u_hpp_if.port_ready_out));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic test_done();
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // busy is polled, a second go while busy would be dropped
    task automatic op(input logic [1:0] s, input logic dir, input logic id,
        input logic [7:0] b);
        apb(1'b1, HPP_OFF_WDATA, {23'h0, id, b});
        // ale off, go on, then direction and select
        apb(1'b1, HPP_OFF_CMD, {27'h0, 2'b01, dir, s});
        r = 32'h1;
        while (r[0] !== 1'b0) apb(1'b0, HPP_OFF_STAT, 32'h0);
    endtask
    task automatic wword(input logic [1:0] s, input logic [15:0] w);
        op(s, 1'b0, 1'b0, w[15:8]);
        op(s, 1'b0, 1'b1, w[7:0]);
    endtask
    task automatic pop(input logic [15:0] w);
        int n = 0;
        @(posedge pclk);
        #1;
        while (wr_valid !== 1'b1 && n < 50) begin
            @(posedge pclk);
            #1;
            n++;
        end
        `CHK("wr_data", w, wr_data)
        @(posedge pclk);
        wr_ready <= 1'b1;
        @(posedge pclk);
        wr_ready <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge pclk);
        `CHK("ready_rst", 1'b1, u_hpp_if.port_ready_out)
        `CHK("holder_rst", 1'b0, holder_on)
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        `CHK("enabled", 1'b1, port_enabled)
        @(posedge pclk);
        port_enable_strap <= 1'b0;
        bank_switch_control_reg <= 16'h0001;
        repeat (2) @(posedge pclk);
        #1;
        `CHK("enabled_kept", 1'b1, port_enabled)
        `CHK("holder_on", 1'b1, holder_on)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("pslverr", 1'b1, e)
        foreach (rows[i]) begin
            wword(rows[i].sel, rows[i].din);
            if (rows[i].sel == HPP_SEL_ADDR)
                `CHK("addr", rows[i].din, host_address_reg)
            if (rows[i].sel == HPP_SEL_CTRL)
                `CHK("ctrl", rows[i].din, host_ctrl_reg)
            if (rows[i].sel == HPP_SEL_DATA_INC)
                `CHK("addr_inc", 16'h0001, host_address_reg)
            if (rows[i].sel[0]) begin
                pop(rows[i].din);
                rd_data <= rows[i].rd;
                for (int k = 0; k < 2; k++) begin
                    op(rows[i].sel, 1'b1, k[0], 8'h00);
                    apb(1'b0, HPP_OFF_RDATA, 32'h0);
                    `CHK("rd", rows[i].rd[8*(1-k) +: 8], r[7:0])
                end
            end
        end
        // fill the buffer with the consumer stalled, then drain in order
        for (int j = 0; j < HPP_FIFO_DEPTH; j++)
            wword(HPP_SEL_DATA, {j[7:0], ~j[7:0]});
        repeat (4) @(posedge pclk);
        #1;
        `CHK("ready_full", 1'b0, u_hpp_if.port_ready_out)
        for (int j = 0; j < HPP_FIFO_DEPTH; j++)
            pop({j[7:0], ~j[7:0]});
        repeat (4) @(posedge pclk);
        #1;
        `CHK("empty", 1'b0, wr_valid)
        `CHK("ready_back", 1'b1, u_hpp_if.port_ready_out)
        @(posedge pclk);
        float_all_n <= 1'b0;
        op(HPP_SEL_DATA, 1'b1, 1'b0, 8'h00);
        float_all_n <= 1'b1;
        gpio_mode <= 1'b1;
        gpio_oe <= 8'hff;
        gpio_out <= 8'h5a;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("gpio_pin", 8'h5a, u_hpp_if.d_i)
        @(posedge pclk);
        gpio_oe <= 8'h00;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("gpio_held", 8'h5a, gpio_in)
        @(posedge pclk);
        gpio_mode <= 1'b0;
        wide_host_mode_strap <= 1'b1;
        wword(HPP_SEL_ADDR, 16'h1357);
        `CHK("addr_wide", rows[2].din, host_address_reg)
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        `CHK("ready_rst2", 1'b1, u_hpp_if.port_ready_out)
        test_done();
    end
endmodule // host_port_pin_interface_tb
